// >>> hdl/xlt_map.svh
// Offsets, field positions and selector codes of the translation fault and array block.
// Assumes inclusion by bare name from the main design file only.
`ifndef XLT_MAP_SVH
`define XLT_MAP_SVH

// ==========================================================
// Mapped array selectors (address bits [31:24] or [31:23])
`define XLT_ITAG_SEL 8'hf2
`define XLT_IDATA_SEL 9'h1e6
`define XLT_UTAG_SEL 8'hf6
`define XLT_ITAG_BASE 32'hf2000000
`define XLT_IDATA_BASE 32'hf3000000
`define XLT_UTAG_BASE 32'hf6000000

// ==========================================================
// Address field positions
`define XLT_ENT_LO 8
`define XLT_ASSOC_BIT 7

// ==========================================================
// Data field positions
`define XLT_VPN_HI 31
`define XLT_VPN_LO 10
`define XLT_DIRTY_BIT 9
`define XLT_VALID_BIT 8
`define XLT_SPACE_ID_HI 7
`define XLT_PPN_HI 28
`define XLT_PPN_LO 10
`define XLT_SZ1_BIT 7
`define XLT_IPR_BIT 6
`define XLT_SZ0_BIT 4
`define XLT_C_BIT 3
`define XLT_SH_BIT 1

// ==========================================================
// Page number compare masks per size code, and reset values
`define XLT_MASK_1K 22'h3fffff
`define XLT_MASK_4K 22'h3ffffc
`define XLT_MASK_64K 22'h3fffc0
`define XLT_MASK_1M 22'h3ffc00
`define XLT_VALID_RST 1'h0
`define XLT_DIRTY_RST 1'h0

`endif

// >>> hdl/xlt_pkg.sv
// Types shared by the translation fault and mapped array logic.
// Assumes nothing beyond a SystemVerilog compiler.
package xlt_pkg;

   // ==========================================================
   // Fault codes, one-hot
   typedef enum logic [4:0] {
      XLT_FLT_NONE = 5'h01,
      XLT_FLT_MULTI = 5'h02,
      XLT_FLT_MISS = 5'h04,
      XLT_FLT_PROT = 5'h08,
      XLT_FLT_FIRSTW = 5'h10
   } xlt_fault_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic valid;
      logic [31:0] vaddr;
      logic write;
      logic priv;
   } xlt_acc_t;

   typedef struct packed {
      logic [21:0] virt_page_number;
      logic [7:0] space_id;
      logic [18:0] phys_page_number;
      logic v;
      logic [1:0] sz;
      logic [1:0] pr;
      logic c;
      logic d;
      logic sh;
      logic wt;
   } xlt_pte_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic write;
      logic [31:0] wdata;
      logic longword;
      logic fetch;
   } xlt_map_t;

   typedef struct packed {
      logic valid;
      xlt_fault_t fault;
      logic [5:0] entry;
   } xlt_res_t;

   typedef struct packed {
      logic [18:0] phys_page_number;
      logic c;
      logic wt;
   } xlt_page_t;

endpackage

// >>> hdl/xlt_page_mem.sv
// Page frame store of the unified buffer: one write port, registered read.
// Assumes single clock; contents are undefined until written.
`timescale 1ns/10ps

module xlt_page_mem #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 64,
   localparam int AW = $clog2(DEPTH)
) (
   input wire logic core_clk,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);

   logic [WIDTH-1:0] mem [DEPTH];

   // ==========================================================
   // Storage write
   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Registered read every cycle
   always_ff @(posedge core_clk) begin
      rdData <= mem[rdAddr];
   end

endmodule

// >>> hdl/xlt_fault_map.sv
// Data-side translation fault detection and mapped translation array access.
// Assumes core pipeline serialises entry loads and array moves; inputs synchronous.
// What this block does
// RULE_01: Data access matching several unified entries raises the multi-match fault.
// RULE_02: Multiple matches during instruction refill search raise the data multi-match fault.
// RULE_03: A data multi-match fault requests reset; frame numbers may be corrupted.
// RULE_04: Data access matching no unified entry raises the translation miss fault.
// RULE_05: Matched access not allowed by the entry rights raises the protection fault.
// RULE_06: Permitted write to a clean matched entry raises the initial write fault.
// RULE_07: The load entry operation copies both page entry registers into a unified entry.
// RULE_08: That entry is the replace counter slot; instruction entries stay untouched.
// RULE_09: Software places the exception return at least one instruction after a load.
// RULE_10: Software moves to mapped arrays only privileged from the uncached window.
// RULE_11: Software branches out of the uncached window no sooner than 8 instructions.
// RULE_12: Mapped arrays accept longword accesses only and never serve fetches.
// RULE_13: Software writes zero to reserved bits; reserved bits read back as anything.
// RULE_14: Valid and dirty are one stored bit each, seen through every array view.
// RULE_15: Instruction tag array sits at selector f2; bits 9:8 pick the entry.
// RULE_16: Instruction tag word: page number 31:10, valid 8, space id 7:0.
// RULE_17: Instruction data array sits at selector f30; bits 9:8 pick the entry.
// RULE_18: Instruction data word: frame 28:10, valid 8, size 7 and 4, rights 6, c 3, shared 1.
// RULE_19: Unified tag array sits at selector f6; bits 13:8 entry, bit 7 associative.
// RULE_20: Unified tag word: page number 31:10, dirty 9, valid 8, space id 7:0.
// RULE_21: Unified tag reads return the selected entry without any comparison.
// RULE_22: Non-associative unified tag write stores all tag fields into the selected entry.
// RULE_23: Associative write updates single match, faults on several, sets matching instruction valid.
`timescale 1ns/10ps
`include "xlt_map.svh"

module xlt_fault_map #(
   parameter int UENT = 64,
   parameter int IENT = 4,
   localparam int UW = $clog2(UENT),
   localparam int IW = $clog2(IENT)
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire xlt_pkg::xlt_acc_t dataAcc,
   input wire xlt_pkg::xlt_acc_t refillAcc,
   input wire logic loadEntry,
   input wire xlt_pkg::xlt_pte_t pteIn,
   input wire logic [UW-1:0] replaceCounter,
   input wire xlt_pkg::xlt_map_t mapAcc,
   output xlt_pkg::xlt_res_t xlatRes,
   output xlt_pkg::xlt_page_t xlatPage,
   output logic refillDone,
   output logic refillHit,
   output logic refillMulti,
   output logic mmuResetReq,
   output logic mapAck,
   output logic mapErr,
   output logic [31:0] mapRdata
);

   // ==========================================================
   // Helpers
   function automatic logic vpnEq(input logic [21:0] a, input logic [21:0] b,
                                  input logic [1:0] sz);
      logic [21:0] m;
      m = (sz == 2'h0) ? `XLT_MASK_1K : (sz == 2'h1) ? `XLT_MASK_4K :
          (sz == 2'h2) ? `XLT_MASK_64K : `XLT_MASK_1M;
      vpnEq = ((a ^ b) & m) == 22'h0;
   endfunction

   function automatic logic severalU(input logic [UENT-1:0] h);
      severalU = |(h & (h - 1'b1));
   endfunction

   function automatic logic [UW-1:0] firstU(input logic [UENT-1:0] h);
      firstU = '0;
      for (int i = UENT - 1; i >= 0; i--) begin
         if (h[i]) begin
            firstU = UW'(i);
         end
      end
   endfunction

   // Privileged: read always, write needs bit 0; user needs bit 1, write needs both
   function automatic logic prOk(input logic [1:0] pr, input logic wr, input logic priv);
      if (priv) begin
         prOk = !wr || pr[0];
      end else begin
         prOk = pr[1] && (!wr || pr[0]);
      end
   endfunction

   // ==========================================================
   // Entry storage
   logic [UENT-1:0] uValid;
   logic [UENT-1:0] uDirty;
   logic [21:0] uVpn [UENT];
   logic [7:0] uAsid [UENT];
   logic [1:0] uSz [UENT];
   logic [1:0] uPr [UENT];
   logic uSh [UENT];
   logic [IENT-1:0] iValid;
   logic [21:0] iVpn [IENT];
   logic [7:0] iAsid [IENT];
   logic [18:0] iPpn [IENT];
   logic [1:0] iSz [IENT];
   logic iPr [IENT];
   logic iC [IENT];
   logic iSh [IENT];

   // ==========================================================
   // Associative searches
   logic [UENT-1:0] dHit;
   logic [UENT-1:0] rHit;
   logic [UENT-1:0] aHit;
   logic [IENT-1:0] aHitI;
   logic [21:0] wrVpn;
   logic [UW-1:0] dIdx;
   logic dMulti;
   logic rMulti;
   logic aMulti;

   assign wrVpn = mapAcc.wdata[`XLT_VPN_HI:`XLT_VPN_LO];

   // Match vectors for data access, refill search and associative write
   always_comb begin
      for (int i = 0; i < UENT; i++) begin
         dHit[i] = uValid[i] && vpnEq(uVpn[i], dataAcc.vaddr[31:10], uSz[i]) &&
                   (uSh[i] || uAsid[i] == pteIn.space_id);
         rHit[i] = uValid[i] && vpnEq(uVpn[i], refillAcc.vaddr[31:10], uSz[i]) &&
                   (uSh[i] || uAsid[i] == pteIn.space_id);
         aHit[i] = uValid[i] && vpnEq(uVpn[i], wrVpn, uSz[i]) &&
                   (uSh[i] || uAsid[i] == pteIn.space_id);
      end
      for (int j = 0; j < IENT; j++) begin
         aHitI[j] = iValid[j] && vpnEq(iVpn[j], wrVpn, iSz[j]) &&
                    (iSh[j] || iAsid[j] == pteIn.space_id);
      end
   end

   assign dIdx = firstU(dHit);
   assign dMulti = severalU(dHit);
   assign rMulti = severalU(rHit);
   assign aMulti = severalU(aHit);

   // ==========================================================
   // Mapped array decode
   logic isItag;
   logic isIdata;
   logic isUtag;
   logic mapGood;
   logic itagWr;
   logic idataWr;
   logic utagWr;
   logic assocWr;
   logic [UW-1:0] uSel;
   logic [IW-1:0] iSel;

   assign isItag = mapAcc.addr[31:24] == `XLT_ITAG_SEL; // RULE_15
   assign isIdata = mapAcc.addr[31:23] == `XLT_IDATA_SEL; // RULE_17
   assign isUtag = mapAcc.addr[31:24] == `XLT_UTAG_SEL; // RULE_19
   assign mapGood = mapAcc.valid && mapAcc.longword && !mapAcc.fetch &&
                    (isItag || isIdata || isUtag); // RULE_12
   assign uSel = mapAcc.addr[`XLT_ENT_LO +: UW];
   assign iSel = mapAcc.addr[`XLT_ENT_LO +: IW];
   assign itagWr = mapGood && mapAcc.write && isItag;
   assign idataWr = mapGood && mapAcc.write && isIdata;
   assign utagWr = mapGood && mapAcc.write && isUtag;
   assign assocWr = utagWr && mapAcc.addr[`XLT_ASSOC_BIT];

   // ==========================================================
   // Unified valid and dirty: one bit each for every view
   always_ff @(posedge core_clk) begin
      if (rst) begin
         uValid <= {UENT{`XLT_VALID_RST}};
         uDirty <= {UENT{`XLT_DIRTY_RST}};
      end else if (loadEntry) begin
         uValid[replaceCounter] <= pteIn.v; // RULE_07
         uDirty[replaceCounter] <= pteIn.d; // RULE_14
      end else if (utagWr && !assocWr) begin
         uValid[uSel] <= mapAcc.wdata[`XLT_VALID_BIT]; // RULE_22
         uDirty[uSel] <= mapAcc.wdata[`XLT_DIRTY_BIT];
      end else if (assocWr && !aMulti) begin
         for (int i = 0; i < UENT; i++) begin
            if (aHit[i]) begin
               uValid[i] <= mapAcc.wdata[`XLT_VALID_BIT]; // RULE_23
               uDirty[i] <= mapAcc.wdata[`XLT_DIRTY_BIT];
            end
         end
      end
   end

   // Unified tag and rights fields, replace counter slot on load
   always_ff @(posedge core_clk) begin
      if (loadEntry) begin
         uVpn[replaceCounter] <= pteIn.virt_page_number; // RULE_08
         uAsid[replaceCounter] <= pteIn.space_id;
         uSz[replaceCounter] <= pteIn.sz;
         uPr[replaceCounter] <= pteIn.pr;
         uSh[replaceCounter] <= pteIn.sh;
      end else if (utagWr && !assocWr) begin
         uVpn[uSel] <= wrVpn; // RULE_22
         uAsid[uSel] <= mapAcc.wdata[`XLT_SPACE_ID_HI:0]; // RULE_20
      end
   end

   // Page frame store; frame read at the matching slot
   xlt_page_mem #(.WIDTH(21), .DEPTH(UENT)) pageMem (
      .core_clk(core_clk),
      .wrEn(loadEntry),
      .wrAddr(replaceCounter),
      .wrData({pteIn.phys_page_number, pteIn.c, pteIn.wt}),
      .rdAddr(dIdx),
      .rdData(xlatPage)
   );

   // ==========================================================
   // Instruction buffer valid: tag view, data view and associative write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         iValid <= {IENT{`XLT_VALID_RST}};
      end else if (itagWr || idataWr) begin
         iValid[iSel] <= mapAcc.wdata[`XLT_VALID_BIT]; // RULE_14
      end else if (assocWr) begin
         for (int j = 0; j < IENT; j++) begin
            if (aHitI[j]) begin
               iValid[j] <= mapAcc.wdata[`XLT_VALID_BIT]; // RULE_23
            end
         end
      end
   end

   // Instruction tag and data fields
   always_ff @(posedge core_clk) begin
      if (itagWr) begin
         iVpn[iSel] <= wrVpn; // RULE_16
         iAsid[iSel] <= mapAcc.wdata[`XLT_SPACE_ID_HI:0];
      end
      if (idataWr) begin
         iPpn[iSel] <= mapAcc.wdata[`XLT_PPN_HI:`XLT_PPN_LO]; // RULE_18
         iSz[iSel] <= {mapAcc.wdata[`XLT_SZ1_BIT], mapAcc.wdata[`XLT_SZ0_BIT]};
         iPr[iSel] <= mapAcc.wdata[`XLT_IPR_BIT];
         iC[iSel] <= mapAcc.wdata[`XLT_C_BIT];
         iSh[iSel] <= mapAcc.wdata[`XLT_SH_BIT];
      end
   end

   // ==========================================================
   // Data access fault classification
   xlt_pkg::xlt_fault_t next_fault;

   always_comb begin
      if (dMulti) begin
         next_fault = xlt_pkg::XLT_FLT_MULTI; // RULE_01
      end else if (dHit == '0) begin
         next_fault = xlt_pkg::XLT_FLT_MISS; // RULE_04
      end else if (!prOk(uPr[dIdx], dataAcc.write, dataAcc.priv)) begin
         next_fault = xlt_pkg::XLT_FLT_PROT; // RULE_05
      end else if (dataAcc.write && !uDirty[dIdx]) begin
         next_fault = xlt_pkg::XLT_FLT_FIRSTW; // RULE_06
      end else begin
         next_fault = xlt_pkg::XLT_FLT_NONE;
      end
   end

   // Result register, one cycle after the access
   always_ff @(posedge core_clk) begin
      if (rst) begin
         xlatRes <= '{valid: 1'b0, fault: xlt_pkg::XLT_FLT_NONE, entry: '0};
      end else begin
         xlatRes.valid <= dataAcc.valid;
         xlatRes.fault <= next_fault;
         xlatRes.entry <= 6'(dIdx);
      end
   end

   // Refill search result
   always_ff @(posedge core_clk) begin
      if (rst) begin
         refillDone <= 1'b0;
         refillHit <= 1'b0;
         refillMulti <= 1'b0;
      end else begin
         refillDone <= refillAcc.valid;
         refillHit <= refillAcc.valid && rHit != '0 && !rMulti;
         refillMulti <= refillAcc.valid && rMulti; // RULE_02
      end
   end

   // Any multi-match fault requests the core reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mmuResetReq <= 1'b0;
      end else begin
         mmuResetReq <= (dataAcc.valid && dMulti) || (refillAcc.valid && rMulti) ||
                        (assocWr && aMulti); // RULE_03
      end
   end

   // ==========================================================
   // Mapped array answer: one cycle after the move, reserved bits zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mapAck <= 1'b0;
         mapErr <= 1'b0;
         mapRdata <= 32'h0;
      end else begin
         mapAck <= mapAcc.valid;
         mapErr <= mapAcc.valid && !mapGood; // RULE_12
         if (mapGood && !mapAcc.write && isItag) begin
            mapRdata <= {iVpn[iSel], 1'b0, iValid[iSel], iAsid[iSel]}; // RULE_16
         end else if (mapGood && !mapAcc.write && isIdata) begin
            mapRdata <= {3'h0, iPpn[iSel], 1'b0, iValid[iSel], iSz[iSel][1], iPr[iSel],
                         1'b0, iSz[iSel][0], iC[iSel], 1'b0, iSh[iSel], 1'b0}; // RULE_18
         end else if (mapGood && !mapAcc.write && isUtag) begin
            mapRdata <= {uVpn[uSel], uDirty[uSel], uValid[uSel], uAsid[uSel]}; // RULE_21
         end else begin
            mapRdata <= 32'h0; // RULE_13
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   multi_fault_a: assert property ( // RULE_01
      dataAcc.valid && dMulti |=> xlatRes.valid && xlatRes.fault == xlt_pkg::XLT_FLT_MULTI)
      else $error("multi-match access not reported");
   refill_multi_a: assert property ( // RULE_02
      refillAcc.valid && rMulti |=> refillMulti && !refillHit && mmuResetReq)
      else $error("refill multi-match not reported as data fault");
   reset_cause_a: assert property ( // RULE_03
      mmuResetReq |-> $past(dataAcc.valid && dMulti || refillAcc.valid && rMulti ||
                            assocWr && aMulti))
      else $error("reset request without a multi-match");
   miss_fault_a: assert property ( // RULE_04
      dataAcc.valid && dHit == '0 |=> xlatRes.fault == xlt_pkg::XLT_FLT_MISS)
      else $error("miss not reported");
   prot_fault_a: assert property ( // RULE_05
      dataAcc.valid && !dMulti && dHit != '0 && !dataAcc.write && !dataAcc.priv &&
      !uPr[dIdx][1] |=> xlatRes.fault == xlt_pkg::XLT_FLT_PROT)
      else $error("user read of privileged page not refused");
   first_write_a: assert property ( // RULE_06
      xlatRes.valid && xlatRes.fault == xlt_pkg::XLT_FLT_FIRSTW |->
      $past(dataAcc.write) && !$past(uDirty[dIdx]))
      else $error("initial write fault without a clean write");
   load_entry_a: assert property ( // RULE_07
      loadEntry |=> uVpn[$past(replaceCounter)] == $past(pteIn.virt_page_number) &&
      uValid[$past(replaceCounter)] == $past(pteIn.v))
      else $error("entry load did not store page entry");
   load_keeps_instr_a: assert property ( // RULE_08
      loadEntry && !mapAcc.valid |=> $stable(iValid))
      else $error("entry load changed instruction buffer");
   longword_only_a: assert property ( // RULE_12
      mapAcc.valid && (!mapAcc.longword || mapAcc.fetch) |=> mapAck && mapErr)
      else $error("non-longword or fetch move accepted");
   utag_read_a: assert property ( // RULE_21
      mapGood && !mapAcc.write && isUtag && !loadEntry |=>
      mapRdata[31:10] == $past(uVpn[uSel]) && mapRdata[9] == $past(uDirty[uSel]))
      else $error("unified tag read returned wrong entry");
   assoc_miss_a: assert property ( // RULE_23
      assocWr && aHit == '0 && !loadEntry |=> $stable(uValid) && $stable(uDirty))
      else $error("associative miss changed unified entries");

endmodule

// >>> verification/xlt_core_model.sv
// Core-side model: issues data accesses, refill searches and mapped array moves.
// Assumes the block takes each request at one edge and answers at the next.
`timescale 1ns/10ps

module xlt_core_model (
   input wire logic core_clk,
   output xlt_pkg::xlt_acc_t dataAcc,
   output xlt_pkg::xlt_acc_t refillAcc,
   output xlt_pkg::xlt_map_t mapAcc
);
   // ==========================================================
   // Idle request carriers at time zero
   initial begin
      dataAcc = '0;
      refillAcc = '0;
      mapAcc = '0;
   end

   // ==========================================================
   // Request tasks; released lines show the inverse of the last value
   task automatic access(input logic [31:0] va, input logic wr, input logic pv);
      @(posedge core_clk);
      dataAcc <= '{1'b1, va, wr, pv};
      @(posedge core_clk);
      dataAcc <= '{1'b0, ~va, ~wr, ~pv};
      #1;
   endtask

   // Refill search from instruction miss handling
   task automatic search(input logic [31:0] va);
      @(posedge core_clk);
      refillAcc <= '{1'b1, va, 1'b0, 1'b1};
      @(posedge core_clk);
      refillAcc <= '{1'b0, ~va, 1'b1, 1'b0};
      #1;
   endtask

   // One mapped array move, privileged, from the uncached window
   task automatic move(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                       input logic lw, input logic fe);
      @(posedge core_clk);
      mapAcc <= '{1'b1, a, wr, wd, lw, fe};
      @(posedge core_clk);
      // Release; the model never branches out of the uncached window after a move
      mapAcc <= '{1'b0, ~a, ~wr, ~wd, ~lw, ~fe};
      #1;
   endtask
endmodule

// >>> verification/tlb_fault_and_mapped_array_access_tb.sv
// Self-checking bench for translation faults and the mapped translation arrays.
// Assumes the core model drives request carriers; the bench drives loads and reset.
`timescale 1ns/10ps

module tlb_fault_and_mapped_array_access_tb;
   localparam logic [7:0] SPACE_ID = 8'h01;
   localparam logic [21:0] V1 = 22'h0abcd;
   localparam logic [21:0] V2 = 22'h12340;
   localparam logic [21:0] V3 = 22'h2f00f;
   localparam logic [21:0] V4 = 22'h33330;
   logic core_clk;
   logic rst;
   logic loadEntry;
   xlt_pkg::xlt_pte_t pteIn;
   logic [5:0] replaceCounter;
   xlt_pkg::xlt_acc_t dataAcc;
   xlt_pkg::xlt_acc_t refillAcc;
   xlt_pkg::xlt_map_t mapAcc;
   xlt_pkg::xlt_res_t xlatRes;
   xlt_pkg::xlt_page_t xlatPage;
   logic refillDone;
   logic refillHit;
   logic refillMulti;
   logic mmuResetReq;
   logic mapAck;
   logic mapErr;
   logic [31:0] mapRdata;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;

   // ==========================================================
   // Design, core model and clock
   xlt_fault_map uut (.core_clk(core_clk), .rst(rst), .dataAcc(dataAcc),
      .refillAcc(refillAcc), .loadEntry(loadEntry), .pteIn(pteIn),
      .replaceCounter(replaceCounter), .mapAcc(mapAcc), .xlatRes(xlatRes),
      .xlatPage(xlatPage), .refillDone(refillDone), .refillHit(refillHit),
      .refillMulti(refillMulti), .mmuResetReq(mmuResetReq), .mapAck(mapAck),
      .mapErr(mapErr), .mapRdata(mapRdata));
   xlt_core_model core (.core_clk(core_clk), .dataAcc(dataAcc), .refillAcc(refillAcc),
      .mapAcc(mapAcc));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Cuts a hung run short
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         test_done();
      end
   end

   // ==========================================================
   // Shared tasks and word builders; reserved bits always zero
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic test_done();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   function automatic logic [31:0] utagW(logic [21:0] virt_page_number, logic d, logic v);
      return {virt_page_number, d, v, SPACE_ID};
   endfunction
   function automatic logic [31:0] itagW(logic [21:0] virt_page_number, logic v);
      return {virt_page_number, 1'b0, v, SPACE_ID};
   endfunction
   function automatic logic [31:0] idataW(logic [18:0] phys_page_number, logic v);
      return {3'h0, phys_page_number, 1'b0, v, 8'b01001010};
   endfunction
   task automatic reset_dut();
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   task automatic load(input logic [5:0] slot, input logic [21:0] virt_page_number, input logic d,
                       input logic [1:0] pr);
      @(posedge core_clk);
      pteIn <= '{virt_page_number, SPACE_ID, {13'h0a5, slot}, 1'b1, 2'b00, pr, 1'b1, d, 1'b0, 1'b0};
      replaceCounter <= slot;
      loadEntry <= 1'b1;
      @(posedge core_clk);
      loadEntry <= 1'b0;
      replaceCounter <= ~slot;
      @(posedge core_clk);
   endtask
   task automatic acc(input logic [21:0] virt_page_number, input logic wr, input logic pv,
                      input xlt_pkg::xlt_fault_t flt);
      core.access({virt_page_number, 10'h15c}, wr, pv);
      check(xlatRes.valid, 1'b1, "result valid");
      check(xlatRes.fault, flt, "fault code");
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      core.move(a, 1'b0, 32'h0, 1'b1, 1'b0);
      check({mapAck, mapErr}, 2'b10, "read ack");
      check(mapRdata, exp, "read data");
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      core.move(a, 1'b1, d, 1'b1, 1'b0);
      check({mapAck, mapErr}, 2'b10, "write ack");
   endtask
   task automatic bad(input logic [31:0] a, input logic lw, input logic fe);
      core.move(a, 1'b1, itagW(V4, 1'b0), lw, fe);
      check({mapAck, mapErr}, 2'b11, "refused move");
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_load_read();
      acc(V1, 1'b0, 1'b1, xlt_pkg::XLT_FLT_MISS);
      load(6'd5, V1, 1'b0, 2'b01);
      rd(32'hf6000500, utagW(V1, 1'b0, 1'b1));
      rd(32'hf6000580, utagW(V1, 1'b0, 1'b1));
      for (int i = 0; i < 4; i++) begin
         core.move(32'hf2000000 + 32'(i * 256), 1'b0, 32'h0, 1'b1, 1'b0);
         check(mapRdata[8], 1'b0, "instruction entry untouched");
      end
   endtask
   task automatic test_faults();
      acc(V1, 1'b0, 1'b1, xlt_pkg::XLT_FLT_NONE);
      check(xlatRes.entry, 6'd5, "hit entry");
      check(xlatPage, {13'h0a5, 6'd5, 2'b10}, "frame");
      acc(V1, 1'b1, 1'b1, xlt_pkg::XLT_FLT_FIRSTW);
      acc(V1, 1'b0, 1'b0, xlt_pkg::XLT_FLT_PROT);
      acc(V1, 1'b1, 1'b0, xlt_pkg::XLT_FLT_PROT);
      acc(V3, 1'b0, 1'b1, xlt_pkg::XLT_FLT_MISS);
   endtask
   task automatic test_multi();
      load(6'd9, V1, 1'b1, 2'b11);
      acc(V1, 1'b0, 1'b1, xlt_pkg::XLT_FLT_MULTI);
      check(mmuResetReq, 1'b1, "reset request");
      core.search({V1, 10'h0});
      check({refillDone, refillMulti, mmuResetReq}, 3'b111, "refill multi");
      reset_dut();
      core.move(32'hf6000900, 1'b0, 32'h0, 1'b1, 1'b0);
      check(mapRdata[9:8], 2'b00, "flags cleared");
      acc(V1, 1'b0, 1'b1, xlt_pkg::XLT_FLT_MISS);
   endtask
   task automatic test_refill();
      load(6'd3, V2, 1'b0, 2'b11);
      core.search({V2, 10'h3fc});
      check({refillDone, refillHit, refillMulti}, 3'b110, "refill hit");
      core.search({V4, 10'h0});
      check({refillDone, refillHit, mmuResetReq}, 3'b100, "refill miss");
   endtask
   task automatic test_instr_arrays();
      wr(32'hf2ab1000, itagW(V2, 1'b1));
      rd(32'hf2000000, itagW(V2, 1'b1));
      wr(32'hf37ffc00, idataW(19'h5a5a5, 1'b0));
      rd(32'hf3000000, idataW(19'h5a5a5, 1'b0));
      rd(32'hf2000000, itagW(V2, 1'b0));
      wr(32'hf3000000, idataW(19'h5a5a5, 1'b1));
      bad(32'hf2000000, 1'b0, 1'b0);
      bad(32'hf2000000, 1'b1, 1'b1);
      bad(32'hf3800000, 1'b1, 1'b0);
      bad(32'hf7000000, 1'b1, 1'b0);
      rd(32'hf2000000, itagW(V2, 1'b1));
   endtask
   task automatic test_assoc();
      wr(32'hf6000080, utagW(V2, 1'b1, 1'b1));
      rd(32'hf6000300, utagW(V2, 1'b1, 1'b1));
      acc(V2, 1'b1, 1'b1, xlt_pkg::XLT_FLT_NONE);
      wr(32'hf6000080, utagW(V2, 1'b0, 1'b0));
      rd(32'hf6000300, utagW(V2, 1'b0, 1'b0));
      rd(32'hf2000000, itagW(V2, 1'b0));
      load(6'd10, V4, 1'b0, 2'b11);
      load(6'd11, V4, 1'b0, 2'b11);
      core.move(32'hf6000080, 1'b1, utagW(V4, 1'b1, 1'b1), 1'b1, 1'b0);
      check(mmuResetReq, 1'b1, "assoc multi");
      wr(32'hf6000080, utagW(V3, 1'b1, 1'b0));
      rd(32'hf6000a00, utagW(V4, 1'b0, 1'b1));
   endtask
   task automatic test_utag_write();
      wr(32'hf6000700, utagW(V3, 1'b1, 1'b1));
      rd(32'hf6000700, utagW(V3, 1'b1, 1'b1));
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      loadEntry = 1'b0;
      pteIn = '0;
      replaceCounter = '0;
      reset_dut();
      test_load_read();
      test_faults();
      test_multi();
      test_refill();
      test_instr_arrays();
      test_assoc();
      test_utag_write();
      test_done();
   end
endmodule
